// File: irps_shaper.v
// infrared pulse shaper between the secondary serial port and its pins, with apb registers
`timescale 1ns/1ps
`include "irps_defs.vh"
module irps_shaper #(
   parameter AW = 12
) (
   // clock and reset
   input  wire          sys_clk,
   input  wire          sys_rst,
   // apb slave
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [AW-1:0] paddr,
   input  wire [31:0]   pwdata,
   output wire [31:0]   prdata,
   output wire          pready,
   output wire          pslverr,
   // secondary serial port, transmit side
   input  wire          uart_txd,
   input  wire          tx_bit_valid,
   input  wire          tx_bit_data,
   output wire          tx_bit_ready,
   // secondary serial port, 16x baud tick and receive input
   input  wire          baud16_tick,
   output wire          uart_rxd,
   // pins
   output wire          secondary_serial_tx_pin,
   input  wire          secondary_serial_rx_pin
);

   // ==================================================
   // address decode

   // one aligned word per register index
   function hit;
      input [AW-1:0] addr;
      input [9:0]    idx;
      begin
         hit = (addr[AW-1:2] == idx[AW-3:0]) && (addr[1:0] == 2'h0);
      end
   endfunction

   // ==================================================
   // declarations

   reg  [6:0]  ctrl_q;
   reg  [31:0] prdata_q;
   reg         pready_q;
   reg         pslverr_q;
   reg  [31:0] rdata_d;
   reg         err_d;

   reg         tx_pin_q;
   reg         bit_act_q;
   reg         bit_val_q;
   reg  [3:0]  sub_q;
   reg         pulse_q;
   reg  [1:0]  ptick_q;

   reg         rx_s1_q;
   reg         rx_s2_q;
   reg         rx_prev_q;
   reg  [4:0]  stretch_q;
   reg         uart_rxd_q;

   wire        ir_shaping_enable;
   wire        prop_mode;
   wire [4:0]  ref_clock_divider;
   wire        pulse_ref_clock;
   wire        fifo_valid;
   wire        fifo_data;
   wire [1:0]  fifo_level;
   wire        bit_end;
   wire        pop;
   wire        start_pulse;
   wire        pulse_step;
   wire        rx_rise;
   wire        stretching;
   wire        wr_go;
   wire        setup;
   wire [6:0]  status;

   // reset value and write mask cut to the seven implemented bits
   localparam [7:0] CTRL_RST = `IRPS_CTRL_RESET;
   localparam [7:0] CTRL_WM  = `IRPS_CTRL_WMASK;

   // ==================================================
   // control fields

   assign ir_shaping_enable = ctrl_q[`IRPS_EN_BIT];
   assign prop_mode         = ctrl_q[`IRPS_MODE_BIT];
   assign ref_clock_divider = ctrl_q[`IRPS_DIV_MSB:`IRPS_DIV_LSB];

   // ==================================================
   // apb slave

   // answer is prepared in the setup cycle, so pready is high in the first access cycle
   assign setup  = psel & ~penable;
   assign wr_go  = psel & penable & pready_q & pwrite;
   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;

   // read mux and unmapped detection
   always @* begin
      rdata_d = 32'h0000_0000;
      err_d   = 1'b1;
      if (hit(paddr, `IRPS_CTRL_IDX)) begin
         rdata_d = {25'h000_0000, ctrl_q}; // reserved bit 7 reads zero
         err_d   = 1'b0;
      end else if (hit(paddr, `IRPS_STAT_IDX)) begin
         rdata_d = {25'h000_0000, status};
         err_d   = 1'b0;
      end
   end

   // bus answer flops
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup & err_d;
         if (setup & ~pwrite)
            prdata_q <= rdata_d;
         else if (!psel)
            prdata_q <= 32'h0000_0000;
      end
   end

   // control register; status is read only, so writes to it are dropped quietly
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_q <= CTRL_RST[6:0];
      end else if (wr_go && hit(paddr, `IRPS_CTRL_IDX)) begin
         ctrl_q <= pwdata[6:0] & CTRL_WM[6:0];
      end
   end

   // ==================================================
   // status word

   assign status[`IRPS_ST_BIT_ACT]                  = bit_act_q;
   assign status[`IRPS_ST_PULSE]                    = pulse_q;
   assign status[`IRPS_ST_STRETCH]                  = stretching;
   assign status[`IRPS_ST_RXPIN]                    = rx_s2_q;
   assign status[`IRPS_ST_LVL_MSB:`IRPS_ST_LVL_LSB] = fifo_level;
   assign status[6]                                 = ir_shaping_enable;

   // ==================================================
   // transmit bit buffer

   // a two-entry buffer lets the port hand over the next bit while the current one plays
   irps_fifo2 #(
      .W (1)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .sys_rst   (sys_rst),
      .in_valid  (tx_bit_valid),
      .in_data   (tx_bit_data),
      .in_ready  (tx_bit_ready),
      .out_valid (fifo_valid),
      .out_data  (fifo_data),
      .out_ready (pop),
      .level     (fifo_level)
   );

   // ==================================================
   // fixed pulse reference

   irps_ref_div #(
      .DW (5)
   ) u_div (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .restart (start_pulse),
      .divisor (ref_clock_divider),
      .tick    (pulse_ref_clock)
   );

   // ==================================================
   // transmit bit timing

   // a bit lasts sixteen baud ticks; the buffer stalls while a bit plays
   assign bit_end = bit_act_q & baud16_tick & (sub_q == (`IRPS_TICKS_PER_BIT - 5'h01));
   assign pop     = fifo_valid & (~bit_act_q | bit_end);
   // only zero bits make a pulse
   assign start_pulse = pop & ~fifo_data;

   // bit sequencer
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bit_act_q <= 1'b0;
         bit_val_q <= 1'b1;
         sub_q     <= 4'h0;
      end else if (pop) begin
         bit_act_q <= 1'b1;
         bit_val_q <= fifo_data;
         sub_q     <= 4'h0;
      end else if (bit_end) begin
         bit_act_q <= 1'b0;
         bit_val_q <= 1'b1;
         sub_q     <= 4'h0;
      end else if (bit_act_q && baud16_tick) begin
         sub_q <= sub_q + 4'h1;
      end
   end

   // ==================================================
   // pulse width

   // fixed mode counts reference periods, so width does not follow the baud rate
   assign pulse_step = prop_mode ? baud16_tick : pulse_ref_clock;

   // pulse timer; a new zero bit always restarts it at the bit start
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pulse_q <= 1'b0;
         ptick_q <= 2'h0;
      end else if (start_pulse) begin
         pulse_q <= 1'b1;
         ptick_q <= 2'h0;
      end else if (pulse_q && pulse_step) begin
         if (prop_mode && (ptick_q == (`IRPS_PROP_TICKS - 2'h1))) begin
            pulse_q <= 1'b0;
            ptick_q <= 2'h0;
         end else if (!prop_mode && (ptick_q == (`IRPS_FIXED_PERIODS - 2'h1))) begin
            pulse_q <= 1'b0;
            ptick_q <= 2'h0;
         end else begin
            ptick_q <= ptick_q + 2'h1;
         end
      end
   end

   // ==================================================
   // transmit pin

   // bypass takes the port's own line level; shaping drives only pulses, idle low
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_pin_q <= 1'b1;
      end else if (ir_shaping_enable) begin
         tx_pin_q <= pulse_q;
      end else begin
         tx_pin_q <= uart_txd;
      end
   end

   assign secondary_serial_tx_pin = tx_pin_q;

   // ==================================================
   // receive path

   // pin crosses in through two flops before anything looks at it
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_s1_q   <= 1'b0;
         rx_s2_q   <= 1'b0;
         rx_prev_q <= 1'b0;
      end else begin
         rx_s1_q   <= secondary_serial_rx_pin;
         rx_s2_q   <= rx_s1_q;
         rx_prev_q <= rx_s2_q;
      end
   end

   assign rx_rise    = rx_s2_q & ~rx_prev_q;
   assign stretching = (stretch_q != 5'h00);

   // stretcher: each pulse starts one bit time of low; a later pulse retriggers it
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stretch_q <= 5'h00;
      end else if (rx_rise) begin
         stretch_q <= `IRPS_STRETCH_TICKS;
      end else if (stretching && baud16_tick) begin
         stretch_q <= stretch_q - 5'h01;
      end
   end

   // receive input to the port; idle level is high in both modes
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         uart_rxd_q <= 1'b1;
      end else if (ir_shaping_enable) begin
         uart_rxd_q <= ~stretching;
      end else begin
         uart_rxd_q <= rx_s2_q;
      end
   end

   assign uart_rxd = uart_rxd_q;

endmodule

// File: irps_defs.vh
// constants of the infrared pulse shaper: register map, fields, reset values, timing counts
// Function
// - while enabled, each zero bit leaves as one high pin pulse; ones give none
// - while enabled, short receive pin pulses are lengthened for the uart receiver
// - shaping off after reset; enable bit is bit 6 of the control register
// - with shaping off, uart transmit and receive go straight to and from pins
// - with shaping on, uart outputs leave the pins; shaper sits in both paths
// - bit 5 picks pulse width: 0 fixed about 1.627us, 1 three sixteenths bit
// - fixed mode pulse width is the same for every bit at any baud rate
// - fixed pulse reference clock is the oscillator divided by bits 4 to 0
// - divider field resets to fifteen
`ifndef IRPS_DEFS_VH
`define IRPS_DEFS_VH
// ==================================================
// register map (indices; byte address is four times the index)
`define IRPS_CTRL_IDX     10'h0CE
`define IRPS_STAT_IDX     10'h0CF
// ==================================================
// control fields
`define IRPS_CTRL_RESET   8'h0F
`define IRPS_EN_BIT       6
`define IRPS_MODE_BIT     5
`define IRPS_DIV_MSB      4
`define IRPS_DIV_LSB      0
`define IRPS_CTRL_WMASK   8'h7F
// ==================================================
// status fields
`define IRPS_ST_BIT_ACT   0
`define IRPS_ST_PULSE     1
`define IRPS_ST_STRETCH   2
`define IRPS_ST_RXPIN     3
`define IRPS_ST_LVL_LSB   4
`define IRPS_ST_LVL_MSB   5
// ==================================================
// timing counts
`define IRPS_TICKS_PER_BIT  5'h10
`define IRPS_FIXED_PERIODS  2'h3
`define IRPS_PROP_TICKS     2'h3
`define IRPS_STRETCH_TICKS  5'h10
`endif

// File: irps_fifo2.v
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module irps_fifo2 #(
   parameter W = 1
) (
   // clock and reset
   input  wire         sys_clk,
   input  wire         sys_rst,
   // filling side
   input  wire         in_valid,
   input  wire [W-1:0] in_data,
   output wire         in_ready,
   // draining side
   output wire         out_valid,
   output wire [W-1:0] out_data,
   input  wire         out_ready,
   // fill level
   output wire [1:0]   level
);
   reg [W-1:0] mem_q [0:1];
   reg         wr_q;
   reg         rd_q;
   reg [1:0]   cnt_q;
   reg         nfull_q;
   reg         nempty_q;
   wire        push = in_valid & nfull_q;
   wire        pop  = out_ready & nempty_q;
   wire [1:0]  cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

   assign in_ready  = nfull_q;
   assign out_valid = nempty_q;
   assign out_data  = mem_q[rd_q];
   assign level     = cnt_q;

   // flags kept as flops so ready never depends on the draining side combinationally
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_q     <= 1'b0;
         rd_q     <= 1'b0;
         cnt_q    <= 2'h0;
         nfull_q  <= 1'b1;
         nempty_q <= 1'b0;
         mem_q[0] <= {W{1'b0}};
         mem_q[1] <= {W{1'b0}};
      end else begin
         if (push) begin
            mem_q[wr_q] <= in_data;
            wr_q        <= ~wr_q;
         end
         if (pop)
            rd_q <= ~rd_q;
         cnt_q    <= cnt_d;
         nfull_q  <= (cnt_d != 2'h2);
         nempty_q <= (cnt_d != 2'h0);
      end
   end
endmodule

// File: irps_ref_div.v
// prescaler making the fixed pulse reference tick from the system clock
`timescale 1ns/1ps
module irps_ref_div #(
   parameter DW = 5
) (
   // clock and reset
   input  wire          sys_clk,
   input  wire          sys_rst,
   // control
   input  wire          restart,
   input  wire [DW-1:0] divisor,
   // one cycle tick per reference period
   output wire          tick
);
   reg [DW-1:0] cnt_q;
   reg          tick_q;
   // divisors of 0 and 1 both tick every cycle
   wire [DW-1:0] last = (divisor == {DW{1'b0}}) ? {DW{1'b0}} : divisor - {{(DW-1){1'b0}}, 1'b1};

   assign tick = tick_q;

   // restart aligns the reference phase to a pulse start, so each pulse is exact
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q  <= {DW{1'b0}};
         tick_q <= 1'b0;
      end else if (restart) begin
         cnt_q  <= {DW{1'b0}};
         tick_q <= 1'b0;
      end else if (cnt_q >= last) begin
         cnt_q  <= {DW{1'b0}};
         tick_q <= 1'b1;
      end else begin
         cnt_q  <= cnt_q + {{(DW-1){1'b0}}, 1'b1};
         tick_q <= 1'b0;
      end
   end
endmodule

// File: irps_shaper_props.sv
// assertions on the bus, serial side and pins of the infrared pulse shaper
`timescale 1ns/1ps
`include "irps_defs.vh"
module irps_shaper_props #(
   parameter AW = 12
) (
   // clock and reset
   input wire          sys_clk,
   input wire          sys_rst,
   // apb
   input wire          psel,
   input wire          penable,
   input wire          pwrite,
   input wire [AW-1:0] paddr,
   input wire [31:0]   pwdata,
   input wire [31:0]   prdata,
   input wire          pready,
   input wire          pslverr,
   // serial port side
   input wire          uart_txd,
   input wire          tx_bit_valid,
   input wire          tx_bit_data,
   input wire          tx_bit_ready,
   input wire          baud16_tick,
   input wire          uart_rxd,
   // pins
   input wire          secondary_serial_tx_pin,
   input wire          secondary_serial_rx_pin
);
   // ==========
   // shadow of the control register and run-length counters
   reg  [6:0] ctrl_q;
   reg  [3:0] dis_q;
   reg  [3:0] tk_q;
   reg  [4:0] rl_q;
   reg  [8:0] en_cnt_q;
   reg  [8:0] hi_q;
   wire       tx = secondary_serial_tx_pin;
   wire       rx = secondary_serial_rx_pin;
   wire       wr = psel & penable & pready & pwrite & ~pslverr & (paddr == {`IRPS_CTRL_IDX, 2'b00});
   wire [6:0] fix_w = (ctrl_q[4:0] < 5'h2) ? 7'h3 : ctrl_q[4:0] * 2'h3;
   // a pulse counts only if it lay wholly inside the enabled stretch
   wire       on = ctrl_q[6] & (en_cnt_q > hi_q);
   // dis_q, en_cnt_q and hi_q saturate so long idle stretches never wrap into a false match; tk_q and rl_q wrap
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_q <= 7'h0F;
         dis_q <= 4'h0;
         en_cnt_q <= 9'h0;
         hi_q <= 9'h0;
         tk_q <= 4'h0;
         rl_q <= 5'h0;
      end else begin
         if (wr) ctrl_q <= pwdata[6:0];
         dis_q <= ctrl_q[6] ? 4'h0 : dis_q + (dis_q != 4'hF);
         en_cnt_q <= ctrl_q[6] ? en_cnt_q + (en_cnt_q != 9'h1FF) : 9'h0;
         hi_q <= tx ? hi_q + (hi_q != 9'h1FF) : 9'h0;
         tk_q <= tx ? tk_q + baud16_tick : 4'h0;
         rl_q <= uart_rxd ? 5'h0 : rl_q + baud16_tick;
      end
   end
   // ==========
   // properties
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   property p_rdy_setup; psel && !penable |=> pready; endproperty
   a_rdy_setup: assert property (p_rdy_setup) else $error("no pready after setup");
   property p_rdy_once; pready |=> !pready; endproperty
   a_rdy_once: assert property (p_rdy_once) else $error("pready longer than one cycle");
   property p_err_rdy; pslverr |-> pready; endproperty
   a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
   property p_byp_tx; dis_q >= 4'h2 |-> tx == $past(uart_txd); endproperty
   a_byp_tx: assert property (p_byp_tx) else $error("tx pin not following port");
   property p_byp_rx; dis_q >= 4'h5 |-> uart_rxd == $past(rx, 3); endproperty
   a_byp_rx: assert property (p_byp_rx) else $error("rx input not following pin");
   property p_fix; $fell(tx) && on && !ctrl_q[5] |-> hi_q >= fix_w - 7'h1 && hi_q <= fix_w + 7'h1; endproperty
   a_fix: assert property (p_fix) else $error("fixed pulse width wrong");
   property p_prop; $fell(tx) && on && ctrl_q[5] |-> tk_q inside {[2:4]}; endproperty
   a_prop: assert property (p_prop) else $error("bit fraction pulse width wrong");
   property p_rx_go; $rose(rx) && ctrl_q[6] && en_cnt_q > 9'h8 |-> ##[1:6] !uart_rxd; endproperty
   a_rx_go: assert property (p_rx_go) else $error("receive pulse not stretched");
   property p_rx_len; $rose(uart_rxd) && en_cnt_q == 9'h1FF |-> rl_q inside {[15:17]}; endproperty
   a_rx_len: assert property (p_rx_len) else $error("stretch length wrong");
   c_fix: cover property ($fell(tx) && on && !ctrl_q[5]);
   c_prop: cover property ($fell(tx) && on && ctrl_q[5]);
   c_rx: cover property ($rose(uart_rxd) && en_cnt_q == 9'h1FF);
endmodule
bind irps_shaper irps_shaper_props #(.AW(AW)) u_props (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .uart_txd(uart_txd), .tx_bit_valid(tx_bit_valid), .tx_bit_data(tx_bit_data),
   .tx_bit_ready(tx_bit_ready), .baud16_tick(baud16_tick), .uart_rxd(uart_rxd),
   .secondary_serial_tx_pin(secondary_serial_tx_pin), .secondary_serial_rx_pin(secondary_serial_rx_pin));

// File: irps_ir_xcvr.sv
// model of the external infrared transceiver on the shaper pins
`timescale 1ns/1ps
module irps_ir_xcvr (
   // clock
   input  wire sys_clk,
   // measurement gate
   input  wire listen,
   // pins
   input  wire tx_pin,
   output reg  rx_q
);
   integer p_cnt;
   integer w_min;
   integer w_max;
   integer w_q;
   initial rx_q = 1'b0;
   // ==========
   // each high stretch on the tx pin is one flash, that is one zero bit
   always @(posedge sys_clk) begin
      if (!listen) begin
         p_cnt <= 0;
         w_q <= 0;
         w_min <= 9999;
         w_max <= 0;
      end else if (tx_pin) begin
         w_q <= w_q + 1;
      end else if (w_q > 0) begin
         p_cnt <= p_cnt + 1;
         w_min <= (w_q < w_min) ? w_q : w_min;
         w_max <= (w_q > w_max) ? w_q : w_max;
         w_q <= 0;
      end
   end
   // ==========
   // receive side: level or one short flash of n cycles
   task set_rx(input v);
      rx_q <= v;
   endtask
   task pulse(input integer n);
      begin
         @(posedge sys_clk);
         rx_q <= 1'b1;
         repeat (n) @(posedge sys_clk);
         rx_q <= 1'b0;
      end
   endtask
endmodule

// File: testbench.sv
// self-checking bench of the infrared pulse shaper
`timescale 1ns/1ps
`include "irps_defs.vh"
module testbench;
   // ==========
   // signals
   reg         sys_clk, sys_rst, psel, penable, pwrite, uart_txd, tx_bit_valid, tx_bit_data, baud16_tick;
   reg         listen_q, er;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, rd, lfsr_q;
   wire [31:0] prdata;
   wire        pready, pslverr, tx_bit_ready, uart_rxd, tx_pin, rx_pin;
   integer     error_cnt, checks_done, cyc, bt, tk, i, j, n, zeros, saw_full, w;
   localparam [11:0] CTRL = {`IRPS_CTRL_IDX, 2'b00};
   localparam [11:0] STAT = {`IRPS_STAT_IDX, 2'b00};
   irps_shaper #(.AW(12)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .uart_txd(uart_txd), .tx_bit_valid(tx_bit_valid), .tx_bit_data(tx_bit_data), .tx_bit_ready(tx_bit_ready),
      .baud16_tick(baud16_tick), .uart_rxd(uart_rxd), .secondary_serial_tx_pin(tx_pin),
      .secondary_serial_rx_pin(rx_pin));
   irps_ir_xcvr xcvr (.sys_clk(sys_clk), .listen(listen_q), .tx_pin(tx_pin), .rx_q(rx_pin));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // one tick source serves both directions, so baud rates always match
   always @(posedge sys_clk) begin
      tk <= (tk >= bt - 1) ? 0 : tk + 1;
      baud16_tick <= (tk >= bt - 1);
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         error_cnt = error_cnt + 1;
         print_verdict;
      end
   end
   // ==========
   // helpers
   function [31:0] lfsr_next(input [31:0] s);
      lfsr_next = {1'b0, s[31:1]} ^ (s[0] ? 32'h80200003 : 32'h0);
   endfunction
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task chk_rng(input integer got, input integer lo, input integer hi);
      chk((got >= lo && got <= hi) ? got : -1, got);
   endtask
   // apb master with no assumed latency
   task apb(input wr, input [11:0] a, input [31:0] d);
      begin
         @(posedge sys_clk);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= wr;
         paddr <= a;
         pwdata <= d;
         @(posedge sys_clk);
         penable <= 1'b1;
         n = 0;
         do begin
            @(posedge sys_clk);
            n = n + 1;
         end while (pready !== 1'b1);
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   // bits go back to back; uart_txd wiggles to show it is cut off
   task send_bits(input integer cnt);
      for (j = 0; j < cnt; j = j + 1) begin
         lfsr_q = lfsr_next(lfsr_q);
         tx_bit_valid <= 1'b1;
         tx_bit_data <= lfsr_q[0];
         uart_txd <= lfsr_q[1];
         zeros = zeros + !lfsr_q[0];
         n = 0;
         do begin
            @(posedge sys_clk);
            n = n + 1;
            if (tx_bit_ready !== 1'b1) saw_full = 1;
         end while (tx_bit_ready !== 1'b1);
         if (j == cnt - 1) tx_bit_valid <= 1'b0;
      end
   endtask
   task print_verdict;
      begin
         $display("errors=%0d checks=%0d", error_cnt, checks_done);
         if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
         else $display("Result: failed");
         $finish;
      end
   endtask
   // ==========
   // main sequence
   initial begin
      {psel, penable, pwrite, tx_bit_valid, tx_bit_data, baud16_tick, listen_q} = 7'h0;
      {paddr, pwdata, rd, er} = 0;
      {uart_txd, sys_rst} = 2'b11;
      {error_cnt, checks_done, cyc, tk, zeros, saw_full} = 0;
      bt = 8;
      lfsr_q = 32'hEB16;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 1'b0;
      apb(0, CTRL, 0);
      chk(rd, {24'h0, `IRPS_CTRL_RESET});
      apb(0, STAT, 0);
      chk(rd[6], 1'b0);
      for (i = 0; i < 4; i = i + 1) begin
         lfsr_q = lfsr_next(lfsr_q);
         w = lfsr_q & `IRPS_CTRL_WMASK;
         apb(1, CTRL, lfsr_q);
         apb(0, CTRL, 0);
         chk(rd, w);
      end
      apb(1, STAT, 32'hFF);
      chk(er, 1'b0);
      apb(0, CTRL, 0);
      chk(rd, w);
      apb(1, 12'h100, 32'h55);
      chk(er, 1'b1);
      apb(0, CTRL + 12'h1, 0);
      chk({er, rd}, {1'b1, 32'h0});
      // straight-through paths
      apb(1, CTRL, 32'h0F);
      for (i = 0; i < 8; i = i + 1) begin
         lfsr_q = lfsr_next(lfsr_q);
         uart_txd <= lfsr_q[0];
         xcvr.set_rx(lfsr_q[1]);
         repeat (5) @(posedge sys_clk);
         chk({tx_pin, uart_rxd}, {lfsr_q[0], lfsr_q[1]});
      end
      uart_txd <= 1'b1;
      xcvr.set_rx(1'b0);
      // shaping: fixed widths at two rates, then bit fraction widths
      for (i = 0; i < 6; i = i + 1) begin
         w = (i == 0) ? 4 : (i == 3) ? 22 : 15;
         bt = (i == 2 || i == 3 || i == 5) ? 12 : 8;
         apb(1, CTRL, 32'h40 | ((i > 3) << 5) | w);
         zeros = 0;
         // let the pin leave its bypass level before the model starts counting flashes
         repeat (2) @(posedge sys_clk);
         listen_q <= 1'b1;
         send_bits(10);
         j = 0;
         do begin
            apb(0, STAT, 0);
            j = j + 1;
         end while ((rd & 32'h33) !== 32'h0 && j < 500);
         repeat (3) @(posedge sys_clk);
         chk(rd & 32'h33, 32'h0);
         chk(xcvr.p_cnt, zeros);
         if (i <= 3) begin
            chk_rng(xcvr.w_min, 3 * w - 1, 3 * w + 1);
            chk_rng(xcvr.w_max, 3 * w - 1, 3 * w + 1);
         end else begin
            chk_rng(xcvr.w_min, 2 * bt, 3 * bt + 2);
            chk_rng(xcvr.w_max, 2 * bt, 3 * bt + 2);
         end
         listen_q <= 1'b0;
      end
      chk(saw_full, 1);
      // receive stretching
      bt = 8;
      chk(uart_rxd, 1'b1);
      xcvr.pulse(2);
      n = 0;
      while (uart_rxd !== 1'b0 && n < 50) begin
         @(posedge sys_clk);
         n = n + 1;
      end
      n = 0;
      while (uart_rxd === 1'b0 && n < 1000) begin
         @(posedge sys_clk);
         n = n + 1;
      end
      chk_rng(n, 15 * bt, 17 * bt + 2);
      print_verdict;
   end
endmodule
